// [pkg/cmpctl_pkg.sv]
package cmpctl_pkg;
    // register word addresses on the avalon bus, data in the low byte lane
    localparam logic [3:0] CMPCTL_ADDR_CTRL1_A = 4'h0;
    localparam logic [3:0] CMPCTL_ADDR_CTRL2_A = 4'h1;
    localparam logic [3:0] CMPCTL_ADDR_CTRL1_B = 4'h2;
    localparam logic [3:0] CMPCTL_ADDR_CTRL2_B = 4'h3;
    localparam logic [3:0] CMPCTL_ADDR_MIRROR  = 4'h4;
    localparam logic [3:0] CMPCTL_ADDR_FLAGS   = 4'h5;
    localparam logic [3:0] CMPCTL_ADDR_PORT    = 4'h6;
    // first control register fields
    localparam int CMPCTL_F_EN     = 7;
    localparam int CMPCTL_F_RESULT = 6;
    localparam int CMPCTL_F_DRIVE  = 5;
    localparam int CMPCTL_F_INV    = 4;
    localparam int CMPCTL_F_SPEED  = 2;
    localparam int CMPCTL_F_HYST   = 1;
    localparam int CMPCTL_F_SYNC   = 0;
    localparam logic [7:0] CMPCTL_CTRL1_WMASK = 8'hb7;
    localparam logic [7:0] CMPCTL_CTRL1_RST   = 8'h04;
    // second control register fields
    localparam int CMPCTL_F_RISE   = 7;
    localparam int CMPCTL_F_FALL   = 6;
    localparam int CMPCTL_F_POS_LO = 4;
    localparam int CMPCTL_F_NEG_LO = 0;
    localparam logic [7:0] CMPCTL_CTRL2_WMASK = 8'hf3;
    localparam logic [7:0] CMPCTL_CTRL2_RST   = 8'h00;
    // positive input routing codes
    localparam logic [1:0] CMPCTL_POS_PIN   = 2'h0;
    localparam logic [1:0] CMPCTL_POS_DAC   = 2'h1;
    localparam logic [1:0] CMPCTL_POS_FIXED = 2'h2;
    localparam logic [1:0] CMPCTL_POS_GND   = 2'h3;
    localparam int CMPCTL_NUM_CMP = 2;
endpackage

// [hw/cmpctl_sync2.sv]
module cmpctl_sync2
    import cmpctl_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic nrst_i,
    // level
    input  wire logic d_i,
    output logic      q_o
);
    logic s1_reg;
    logic s2_reg;
    logic s1_next;
    logic s2_next;

    always_comb begin
        s1_next = d_i;
        s2_next = s1_reg;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
        end
    end

    assign q_o = s2_reg;
endmodule // cmpctl_sync2

// [hw/cmpctl_slice.sv]
module cmpctl_slice
    import cmpctl_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // control values
    input  wire logic [7:0] ctrl1_i,
    input  wire logic [7:0] ctrl2_i,
    // analog core and timer, already synchronised
    input  wire logic       raw_s_i,
    input  wire logic       tclk_s_i,
    // results
    output logic            result_o,
    output logic            sync_out_o,
    output logic            edge_o
);
    logic pol_res;
    logic res_reg;
    logic res_next;
    logic tclk_d_reg;
    logic tclk_d_next;
    logic held_reg;
    logic held_next;
    logic init_reg;
    logic init_next;
    logic tfall;

    assign pol_res = raw_s_i ^ ctrl1_i[CMPCTL_F_INV];
    assign tfall   = tclk_d_reg & ~tclk_s_i;

    always_comb begin
        res_next    = pol_res;
        tclk_d_next = tclk_s_i;
        init_next   = 1'b1;
        held_next   = tfall ? res_reg : held_reg;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            res_reg    <= 1'b0;
            tclk_d_reg <= 1'b0;
            held_reg   <= 1'b0;
            init_reg   <= 1'b0;
        end else begin
            res_reg    <= res_next;
            tclk_d_reg <= tclk_d_next;
            held_reg   <= held_next;
            init_reg   <= init_next;
        end
    end

    assign result_o   = res_reg;
    assign sync_out_o = ctrl1_i[CMPCTL_F_SYNC] ? held_reg : res_reg;
    // edge on the registered result, even while disabled
    assign edge_o = init_reg & (
                    (ctrl2_i[CMPCTL_F_RISE] & res_next & ~res_reg)
                  | (ctrl2_i[CMPCTL_F_FALL] & ~res_next & res_reg));
endmodule // cmpctl_slice

// [hw/cmpctl_top.sv]
module cmpctl_top
    import cmpctl_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic [1:0]       avs_response_o,
    // analog core, per comparator
    input  wire logic [1:0]  cmp_raw_i,
    output logic [1:0]       cmp_enable_o,
    output logic [1:0]       cmp_speed_sel_o,
    output logic [1:0]       cmp_hyst_en_o,
    output logic [3:0]       pos_input_sel_o,
    output logic [3:0]       neg_input_sel_o,
    output logic [1:0]       pos_connect_o,
    output logic [1:0]       neg_connect_o,
    // gate timer, prescaled clock
    input  wire logic        gate_tclk_i,
    output logic [1:0]       gate_result_o,
    // pwm shutdown
    output logic [1:0]       pwm_shutdown_src_o,
    // output pins
    input  wire logic [1:0]  pin_direction_i,
    output logic [1:0]       cmp_pin_o,
    output logic [1:0]       cmp_pin_oe_o,
    // digital port readback
    input  wire logic [7:0]  port_pins_i,
    input  wire logic [7:0]  analog_pin_select_i,
    // event flags
    output logic [1:0]       cmp_event_flag_o
);
    logic [7:0]  ctrl1_reg [CMPCTL_NUM_CMP];
    logic [7:0]  ctrl1_next[CMPCTL_NUM_CMP];
    logic [7:0]  ctrl2_reg [CMPCTL_NUM_CMP];
    logic [7:0]  ctrl2_next[CMPCTL_NUM_CMP];
    logic [1:0]  flag_reg;
    logic [1:0]  flag_next;
    logic        ack_reg;
    logic        ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0]  resp_reg;
    logic [1:0]  resp_next;
    logic [1:0]  raw_s;
    logic        tclk_s;
    logic [7:0]  port_s;
    logic [1:0]  result;
    logic [1:0]  sync_out;
    logic [1:0]  edge_hit;
    logic        req;
    logic        wr;
    logic        lane0;
    logic        mapped;
    logic [7:0]  rbyte;
    logic [7:0]  rd_ctrl1 [CMPCTL_NUM_CMP];

    // pin-side inputs pass two flops
    cmpctl_sync2 u_sync_tclk (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (gate_tclk_i),
        .q_o    (tclk_s)
    );

    genvar g;
    generate
        for (g = 0; g < CMPCTL_NUM_CMP; g++) begin : g_cmp
            cmpctl_sync2 u_sync_raw (
                .clk_i  (clk_i),
                .nrst_i (nrst_i),
                .d_i    (cmp_raw_i[g]),
                .q_o    (raw_s[g])
            );
            cmpctl_slice u_slice (
                .clk_i      (clk_i),
                .nrst_i     (nrst_i),
                .ctrl1_i    (ctrl1_reg[g]),
                .ctrl2_i    (ctrl2_reg[g]),
                .raw_s_i    (raw_s[g]),
                .tclk_s_i   (tclk_s),
                .result_o   (result[g]),
                .sync_out_o (sync_out[g]),
                .edge_o     (edge_hit[g])
            );
            assign cmp_enable_o[g]    = ctrl1_reg[g][CMPCTL_F_EN];
            assign cmp_speed_sel_o[g] = ctrl1_reg[g][CMPCTL_F_SPEED];
            assign cmp_hyst_en_o[g]   = ctrl1_reg[g][CMPCTL_F_HYST];
            assign pos_input_sel_o[2*g+1:2*g] =
                ctrl2_reg[g][CMPCTL_F_POS_LO+1:CMPCTL_F_POS_LO];
            assign neg_input_sel_o[2*g+1:2*g] =
                ctrl2_reg[g][CMPCTL_F_NEG_LO+1:CMPCTL_F_NEG_LO];
            assign pos_connect_o[g] = ctrl1_reg[g][CMPCTL_F_EN];
            assign neg_connect_o[g] = ctrl1_reg[g][CMPCTL_F_EN];
            assign gate_result_o[g]      = sync_out[g];
            assign pwm_shutdown_src_o[g] = sync_out[g];
            // pin override ignores the enable bit
            assign cmp_pin_o[g]    = sync_out[g];
            assign cmp_pin_oe_o[g] = ctrl1_reg[g][CMPCTL_F_DRIVE]
                                   & ~pin_direction_i[g];
            assign rd_ctrl1[g] = {ctrl1_reg[g][7], result[g], ctrl1_reg[g][5:0]};
        end
    endgenerate

    generate
        for (g = 0; g < 8; g++) begin : g_port
            cmpctl_sync2 u_sync_port (
                .clk_i  (clk_i),
                .nrst_i (nrst_i),
                .d_i    (port_pins_i[g]),
                .q_o    (port_s[g])
            );
        end
    endgenerate

    // bus decode: one-cycle wait then a registered answer
    assign req    = (avs_read_i | avs_write_i) & ~ack_reg;
    assign wr     = avs_write_i;
    assign lane0  = avs_byteenable_i[0];
    assign mapped = avs_address_i <= CMPCTL_ADDR_PORT;

    always_comb begin
        rbyte = 8'h00;
        case (avs_address_i)
            CMPCTL_ADDR_CTRL1_A: rbyte = rd_ctrl1[0];
            CMPCTL_ADDR_CTRL2_A: rbyte = ctrl2_reg[0];
            CMPCTL_ADDR_CTRL1_B: rbyte = rd_ctrl1[1];
            CMPCTL_ADDR_CTRL2_B: rbyte = ctrl2_reg[1];
            CMPCTL_ADDR_MIRROR:  rbyte = {6'h00, result[1], result[0]};
            CMPCTL_ADDR_FLAGS:   rbyte = {6'h00, flag_reg};
            CMPCTL_ADDR_PORT:    rbyte = port_s & ~analog_pin_select_i;
            default:             rbyte = 8'h00;
        endcase
    end

    always_comb begin
        ack_next   = req;
        rdata_next = rdata_reg;
        resp_next  = resp_reg;
        ctrl1_next = ctrl1_reg;
        ctrl2_next = ctrl2_reg;
        flag_next  = flag_reg;
        if (req) begin
            resp_next  = mapped ? 2'h0 : 2'h2;
            rdata_next = wr ? 32'h0000_0000 : {24'h00_0000, rbyte};
        end
        if (req && wr && lane0) begin
            case (avs_address_i)
                CMPCTL_ADDR_CTRL1_A: ctrl1_next[0] = (ctrl1_reg[0] & ~CMPCTL_CTRL1_WMASK)
                    | (avs_writedata_i[7:0] & CMPCTL_CTRL1_WMASK);
                CMPCTL_ADDR_CTRL2_A: ctrl2_next[0] = avs_writedata_i[7:0] & CMPCTL_CTRL2_WMASK;
                CMPCTL_ADDR_CTRL1_B: ctrl1_next[1] = (ctrl1_reg[1] & ~CMPCTL_CTRL1_WMASK)
                    | (avs_writedata_i[7:0] & CMPCTL_CTRL1_WMASK);
                CMPCTL_ADDR_CTRL2_B: ctrl2_next[1] = avs_writedata_i[7:0] & CMPCTL_CTRL2_WMASK;
                CMPCTL_ADDR_FLAGS:   flag_next = avs_writedata_i[1:0];
                default:             ;
            endcase
        end
        flag_next = flag_next | edge_hit;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < CMPCTL_NUM_CMP; i++) begin
                ctrl1_reg[i] <= CMPCTL_CTRL1_RST;
                ctrl2_reg[i] <= CMPCTL_CTRL2_RST;
            end
            flag_reg  <= 2'h0;
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            resp_reg  <= 2'h0;
        end else begin
            ctrl1_reg <= ctrl1_next;
            ctrl2_reg <= ctrl2_next;
            flag_reg  <= flag_next;
            ack_reg   <= ack_next;
            rdata_reg <= rdata_next;
            resp_reg  <= resp_next;
        end
    end

    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
    assign avs_readdata_o    = rdata_reg;
    assign avs_response_o    = resp_reg;
    assign cmp_event_flag_o  = flag_reg;
endmodule // cmpctl_top

// [dv/cmpctl_sva.sv]
module cmpctl_sva
    import cmpctl_pkg::*;
(
    // clock, reset and bus
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    // comparator side
    input wire logic [1:0]  cmp_enable_o,
    input wire logic [1:0]  cmp_speed_sel_o,
    input wire logic [1:0]  pos_connect_o,
    input wire logic [1:0]  neg_connect_o,
    input wire logic [1:0]  gate_result_o,
    input wire logic [1:0]  pwm_shutdown_src_o,
    input wire logic [1:0]  cmp_pin_o,
    input wire logic [1:0]  cmp_pin_oe_o,
    input wire logic [1:0]  pin_direction_i,
    input wire logic [7:0]  analog_pin_select_i,
    input wire logic [1:0]  cmp_event_flag_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    rst_vals_a:
        assert property ($rose(nrst_i) |-> cmp_enable_o == 2'h0 && cmp_speed_sel_o == 2'h3)
        else $error("control outputs not at reset values");
    one_wait_a:
        assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus answer not after one wait cycle");
    data_stands_a:
        assert property (!avs_read_i && !avs_write_i |=> $stable(avs_readdata_o))
        else $error("read data changed while idle");
    flag_clear_a:
        assert property ($fell(cmp_event_flag_o[0]) || $fell(cmp_event_flag_o[1]) |->
            $past(avs_write_i) && $past(avs_address_i) == CMPCTL_ADDR_FLAGS)
        else $error("event flag cleared without a write");
    port_zero_a:
        assert property (avs_read_i && avs_address_i == CMPCTL_ADDR_PORT && avs_waitrequest_o
            |=> (avs_readdata_o[7:0] & $past(analog_pin_select_i)) == 8'h00)
        else $error("analog pin read back nonzero");
    mirror_upper_a:
        assert property (avs_read_i && avs_address_i == CMPCTL_ADDR_MIRROR && avs_waitrequest_o
            |=> avs_readdata_o[31:2] == 30'h0)
        else $error("mirror upper bits nonzero");
    pin_drive_a:
        assert property ((cmp_pin_oe_o & pin_direction_i) == 2'h0)
        else $error("pin driven while direction is input");
    inputs_cut_a:
        assert property (pos_connect_o == cmp_enable_o && neg_connect_o == cmp_enable_o)
        else $error("input paths do not follow enable");
    result_fanout_a:
        assert property (pwm_shutdown_src_o == gate_result_o && cmp_pin_o == gate_result_o)
        else $error("result outputs disagree");
    cover property ($rose(cmp_event_flag_o[0]));
    cover property ($rose(cmp_event_flag_o[1]));
    cover property ($rose(cmp_pin_oe_o[0]));
endmodule // cmpctl_sva

bind cmpctl_top cmpctl_sva u_sva (.*);

// [dv/cmpctl_partner.sv]
module cmpctl_partner (
    // node comparison and input connection
    input  wire logic [1:0] pos_gt_i,
    input  wire logic [1:0] connect_i,
    // gate timer clock burst request
    input  wire logic       tclk_run_i,
    output logic [1:0]      raw_o,
    output logic            tclk_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // disconnected comparator gives a low output
    assign raw_o = pos_gt_i & connect_i;
    initial begin
        tclk_o = 1'b0;
        forever begin
            #85;
            // timer clock stands low outside bursts
            tclk_o = tclk_run_i ? ~tclk_o : 1'b0;
        end
    end
endmodule // cmpctl_partner

// [dv/test_cmpctl_top.sv]
module test_cmpctl_top
    import cmpctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0, nrst_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [3:0]  avs_address_i = 4'h0, avs_byteenable_i = 4'hf, a1, a2;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
    logic        avs_waitrequest_o, gate_tclk_i, tclk_run = 1'b0;
    logic [1:0]  avs_response_o, cmp_raw_i, cmp_enable_o, cmp_speed_sel_o, cmp_hyst_en_o;
    logic [1:0]  pos_connect_o, neg_connect_o, gate_result_o, pwm_shutdown_src_o, cmp_pin_o;
    logic [1:0]  cmp_pin_oe_o, cmp_event_flag_o, rsp, pin_direction_i = 2'h3, pos_gt = 2'h0;
    logic [3:0]  pos_input_sel_o, neg_input_sel_o;
    logic [7:0]  port_pins_i = 8'h00, analog_pin_select_i = 8'h00, rd, fb;
    int          fail_count = 0, cmp_count = 0, cyc = 0;

    cmpctl_top DUT (.*);
    cmpctl_partner u_far (.pos_gt_i(pos_gt), .connect_i(pos_connect_o),
        .tclk_run_i(tclk_run), .raw_o(cmp_raw_i), .tclk_o(gate_tclk_i));

    initial forever #25 clk_i = ~clk_i;

    task automatic results();
        if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_writedata_i <= {24'h0, d};
        // if waitrequest never falls, only the bench timeout ends this wait
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o[7:0];
        rsp = avs_response_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(rd, e);
    endtask

    task automatic burst();
        tclk_run <= 1'b1;
        repeat (20) @(posedge clk_i);
        tclk_run <= 1'b0;
        repeat (10) @(posedge clk_i);
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        for (int g = 0; g < 2; g++) begin
            a1 = g ? CMPCTL_ADDR_CTRL1_B : CMPCTL_ADDR_CTRL1_A;
            a2 = a1 + 4'h1;
            fb = 8'h01 << g;
            rdc(a1, CMPCTL_CTRL1_RST);
            rdc(a2, CMPCTL_CTRL2_RST);
            chk({6'h0, rsp}, 8'h00);
            acc(1'b1, a1, 8'h82);
            chk({cmp_enable_o[g], cmp_hyst_en_o[g], cmp_speed_sel_o[g], pos_connect_o[g],
                neg_connect_o[g]}, 8'h1b);
            for (int c = 0; c < 4; c++) begin
                acc(1'b1, a2, {2'h0, 2'(c), 2'h0, 2'(c)});
                chk({pos_input_sel_o[2*g+:2], neg_input_sel_o[2*g+:2]}, 8'(c * 5));
            end
            acc(1'b1, a2, 8'h80);
            pos_gt[g] <= 1'b1;
            // clearing write lands on the edge that sees the rise
            repeat (2) @(posedge clk_i);
            acc(1'b1, CMPCTL_ADDR_FLAGS, 8'h00);
            rdc(a1, 8'hc2);
            rdc(CMPCTL_ADDR_MIRROR, fb);
            rdc(CMPCTL_ADDR_FLAGS, fb);
            chk({6'h0, cmp_event_flag_o}, fb);
            acc(1'b1, CMPCTL_ADDR_FLAGS, 8'h00);
            rdc(CMPCTL_ADDR_FLAGS, 8'h00);
            chk({6'h0, cmp_event_flag_o}, 8'h00);
            acc(1'b1, a1, 8'h92);
            repeat (6) @(posedge clk_i);
            rdc(a1, 8'h92);
            rdc(CMPCTL_ADDR_FLAGS, 8'h00);
            acc(1'b1, a2, 8'h40);
            acc(1'b1, a1, 8'h82);
            repeat (6) @(posedge clk_i);
            rdc(CMPCTL_ADDR_FLAGS, 8'h00);
            acc(1'b1, a1, 8'h92);
            repeat (6) @(posedge clk_i);
            rdc(CMPCTL_ADDR_FLAGS, fb);
            acc(1'b1, CMPCTL_ADDR_FLAGS, 8'h00);
            acc(1'b1, a1, 8'h34);
            pin_direction_i <= 2'h0;
            repeat (6) @(posedge clk_i);
            chk({cmp_pin_oe_o[g], cmp_pin_o[g], gate_result_o[g], pwm_shutdown_src_o[g]},
                8'h0f);
            pin_direction_i <= 2'h3;
            repeat (2) @(posedge clk_i);
            chk({7'h0, cmp_pin_oe_o[g]}, 8'h00);
            acc(1'b1, a1, 8'h85);
            burst();
            pos_gt[g] <= 1'b0;
            repeat (8) @(posedge clk_i);
            chk({7'h0, gate_result_o[g]}, 8'h01);
            burst();
            chk({7'h0, gate_result_o[g]}, 8'h00);
            acc(1'b1, a2, 8'h00);
            acc(1'b1, a1, 8'h04);
            acc(1'b1, CMPCTL_ADDR_FLAGS, 8'h00);
        end
        // a write without the low byte lane changes nothing
        avs_byteenable_i <= 4'he;
        acc(1'b1, CMPCTL_ADDR_CTRL2_A, 8'hff);
        avs_byteenable_i <= 4'hf;
        rdc(CMPCTL_ADDR_CTRL2_A, 8'h00);
        port_pins_i <= 8'hff;
        analog_pin_select_i <= 8'h0f;
        repeat (6) @(posedge clk_i);
        rdc(CMPCTL_ADDR_PORT, 8'hf0);
        rdc(4'hf, 8'h00);
        chk({6'h0, rsp}, 8'h02);
        results();
    end
endmodule // test_cmpctl_top
